// File: hdl/dwte_consts.svh
// constants for the dac waveform timing engine
`ifndef DWTE_CONSTS_SVH
`define DWTE_CONSTS_SVH
`define DWTE_A_CTRL      4'h0
`define DWTE_A_MODE      4'h1
`define DWTE_A_COUNT     4'h2
`define DWTE_A_DIV       4'h3
`define DWTE_A_DELAY     4'h4
`define DWTE_A_GOSRC     4'h5
`define DWTE_A_HOLDSRC   4'h6
`define DWTE_A_STRBSRC   4'h7
`define DWTE_A_ROUTE     4'h8
`define DWTE_A_DATA      4'h9
`define DWTE_A_STATUS    4'ha
`define DWTE_A_OUTVAL    4'hb
`define DWTE_C_START     0
`define DWTE_C_STOP      1
`define DWTE_C_SWPULSE   2
`define DWTE_C_CLRERR    3
`define DWTE_C_CONVERT   4
`define DWTE_C_LOADDONE  5
`define DWTE_DELAY_RST   16'h0002
`define DWTE_DIV_RST     16'h0004
`endif

// File: hdl/dwte_pkg.sv
// types for the dac waveform timing engine
package dwte_pkg;
	typedef enum logic [2:0] {
		DWTE_SWTIMED, DWTE_FINITE, DWTE_CONT_REGEN, DWTE_FIFO_REGEN,
		DWTE_NONREGEN, DWTE_NONBUF
	} dwte_mode_t;
	typedef enum logic [2:0] {
		DWTE_GO_NONE, DWTE_GO_HOST, DWTE_GO_PIO, DWTE_GO_IBL,
		DWTE_GO_INREF, DWTE_GO_INBEGIN, DWTE_GO_STAR, DWTE_GO_ANALOG
	} dwte_gosrc_t;
	typedef enum logic [2:0] {
		DWTE_HS_NONE, DWTE_HS_PIO, DWTE_HS_IBL, DWTE_HS_STAR, DWTE_HS_ANALOG
	} dwte_holdsrc_t;
	typedef enum logic [2:0] {
		DWTE_SS_DIVIDER, DWTE_SS_COUNTER, DWTE_SS_PIO, DWTE_SS_IBL,
		DWTE_SS_STAR, DWTE_SS_ANALOG
	} dwte_strbsrc_t;
	typedef enum logic [1:0] {
		DWTE_IDLE, DWTE_DELAY, DWTE_RUN
	} dwte_state_t;
endpackage

// File: hdl/dwte_timing_engine.sv
// waveform timing engine: triggers, pause, update strobe, sample fifo
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "dwte_consts.svh"
//
// Contract
// - software command gives exactly one conversion
// - hardware mode paced by timing strobe
// - buffered mode: one fifo sample per update
// - finite mode stops after programmed count
// - continuous mode runs until stop command or fifo underflow
// - fifo regeneration replays, blocks later writes
// - non-regeneration never repeats, flags underflow
// - non-buffered writes bypass fifo, next update
// - start on trigger, else software start
// - selectable digital start source and edge
// - analog start on first rising edge
// - routed start is active-high, terminals input default
// - pause suppresses all strobed sample updates, not software conversions
// - pause acts from next sample only
// - onboard strobe resumes at once after pause
// - other strobe drops first edge after pause, resumes on the second
// - digital pause source with level polarity
// - analog pause holds while event high
// - pause routes out only to inter-board lines
// - one strobe updates all channels, edge selectable
// - strobe from divider, counter or external
// - start-to-first-strobe delay for onboard strobe only, default two ticks
// - routed update strobe is active low
module dwte_timing_engine import dwte_pkg::*; #(
	parameter int CHANNELS = 4,
	parameter int DACW     = 16,
	parameter int DEPTH    = 16,
	parameter int AW       = 4
) (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic [3:0]               regAddr,
	input  wire logic [31:0]              regWdata,
	input  wire logic                     regWrite,
	input  wire logic                     regRead,
	output logic      [31:0]              regRdata,
	input  wire logic [15:0]              pioIn,
	output logic      [15:0]              pioOut,
	output logic      [15:0]              pioOe_n,
	input  wire logic [7:0]               iblIn,
	output logic      [7:0]               iblOut,
	output logic      [7:0]               iblOe_n,
	input  wire logic                     starIn,
	input  wire logic                     analogEvent,
	input  wire logic                     inputStopRefEvent,
	input  wire logic                     inputBeginEvent,
	input  wire logic                     counterOut,
	input  wire logic                     sourceClockTick,
	output logic      [CHANNELS*DACW-1:0] dacData,
	output logic                          dacUpdate,
	output logic                          running
);
	localparam int NS = 16 + 8 + 5;
	localparam int WPF = DACW * CHANNELS;

	logic [NS-1:0] syncA_reg, syncB_reg, syncC_reg;
	logic [2:0]  mode_reg;
	logic [15:0] count_reg, div_reg, delay_reg;
	logic [7:0]  goSrc_reg, holdSrc_reg, strbSrc_reg;
	logic [31:0] route_reg;
	logic        err_reg, loaded_reg;
	logic [WPF-1:0] fifo [DEPTH];
	logic [AW:0]  wp_reg, rp_reg, fill_reg, loadCnt_reg;
	logic [15:0]  done_reg, divCnt_reg, dly_reg;
	logic [WPF-1:0] direct_reg, dac_reg;
	logic        directNew_reg, upd_reg, pend_reg, heldWait_reg;
	logic [31:0] rd_reg;
	logic        goOut_reg;
	dwte_state_t state_reg;

	// two flip-flops, then a third stage for edge detection
	wire [NS-1:0] raw = {inputBeginEvent, inputStopRefEvent, counterOut,
		analogEvent, starIn, iblIn, pioIn};
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
			syncC_reg <= '0;
		end else begin
			syncA_reg <= raw;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
		end
	end
	wire [NS-1:0] lvl = syncB_reg;
	wire [NS-1:0] rise = syncB_reg & ~syncC_reg;
	wire [NS-1:0] fall = ~syncB_reg & syncC_reg;

	wire dwte_mode_t    mode = dwte_mode_t'(mode_reg);
	wire dwte_gosrc_t   goSrc = dwte_gosrc_t'(goSrc_reg[2:0]);
	wire dwte_holdsrc_t holdSrc = dwte_holdsrc_t'(holdSrc_reg[2:0]);
	wire dwte_strbsrc_t strbSrc = dwte_strbsrc_t'(strbSrc_reg[2:0]);
	wire [4:0] goSel = goSrc_reg[7:3];
	wire goEdgeFall = route_reg[31];
	wire holdLow = holdSrc_reg[7];
	wire strbFall = strbSrc_reg[7];
	wire [4:0] hSel = holdSrc_reg[7:3] & 5'h0f;
	wire [4:0] sSel = strbSrc_reg[7:3];

	wire wrCtrl = regWrite && regAddr == `DWTE_A_CTRL;
	wire cStart = wrCtrl && regWdata[`DWTE_C_START];
	wire cStop = wrCtrl && regWdata[`DWTE_C_STOP];
	wire cPulse = wrCtrl && regWdata[`DWTE_C_SWPULSE];
	wire cClr = wrCtrl && regWdata[`DWTE_C_CLRERR];
	wire cConv = wrCtrl && regWdata[`DWTE_C_CONVERT];
	wire cLoadDone = wrCtrl && regWdata[`DWTE_C_LOADDONE];
	wire wrData = regWrite && regAddr == `DWTE_A_DATA;

	wire [NS-1:0] goEdges = goEdgeFall ? fall : rise;
	logic goPick;
	always_comb begin
		goPick = 1'b0;
		unique case (goSrc)
			DWTE_GO_NONE:    goPick = cStart;
			DWTE_GO_HOST:    goPick = cPulse;
			DWTE_GO_PIO:     goPick = goEdges[goSel[3:0]];
			DWTE_GO_IBL:     goPick = goEdges[16 + goSel[2:0]];
			DWTE_GO_INREF:   goPick = goEdges[27];
			DWTE_GO_INBEGIN: goPick = goEdges[28];
			DWTE_GO_STAR:    goPick = goEdges[24];
			DWTE_GO_ANALOG:  goPick = rise[25];
		endcase
	end
	wire go = goPick && (goSrc == DWTE_GO_NONE || cStart ||
		state_reg == DWTE_IDLE) && mode != DWTE_SWTIMED;

	logic holdRaw;
	always_comb begin
		holdRaw = 1'b0;
		unique case (holdSrc)
			DWTE_HS_PIO:    holdRaw = lvl[hSel[3:0]] ^ holdLow;
			DWTE_HS_IBL:    holdRaw = lvl[16 + hSel[2:0]] ^ holdLow;
			DWTE_HS_STAR:   holdRaw = lvl[24] ^ holdLow;
			DWTE_HS_ANALOG: holdRaw = lvl[25];
			default:        holdRaw = 1'b0;
		endcase
	end

	// strobe sources; divider ticks on source clock edges
	wire divTick = sourceClockTick && state_reg != DWTE_IDLE;
	wire divWrap = divTick && divCnt_reg == 16'h0000;
	wire [NS-1:0] sEdges = strbFall ? fall : rise;
	logic extStrb;
	always_comb begin
		extStrb = 1'b0;
		unique case (strbSrc)
			DWTE_SS_COUNTER: extStrb = sEdges[26];
			DWTE_SS_PIO:     extStrb = sEdges[sSel[3:0]];
			DWTE_SS_IBL:     extStrb = sEdges[16 + sSel[2:0]];
			DWTE_SS_STAR:    extStrb = sEdges[24];
			DWTE_SS_ANALOG:  extStrb = sEdges[25];
			default:         extStrb = 1'b0;
		endcase
	end
	wire onboard = strbSrc == DWTE_SS_DIVIDER;
	wire strobe = state_reg == DWTE_RUN && (onboard ? divWrap : extStrb);

	// pause gating; sample in flight finishes
	wire holdBlock = holdRaw || (heldWait_reg && !onboard);
	wire updEvent = strobe && !holdBlock;

	wire buffered = mode != DWTE_SWTIMED && mode != DWTE_NONBUF;
	wire empty = fill_reg == '0;
	wire full = fill_reg == (AW+1)'(DEPTH);
	wire regen = mode == DWTE_FIFO_REGEN || mode == DWTE_CONT_REGEN;
	// writes refused after loading in fifo regeneration
	wire fifoWr = wrData && buffered && !full &&
		!(mode == DWTE_FIFO_REGEN && loaded_reg);
	wire take = updEvent && buffered && !empty;
	wire under = updEvent && buffered && empty &&
		(mode == DWTE_NONREGEN || mode == DWTE_CONT_REGEN);
	wire finDone = mode == DWTE_FINITE && take &&
		done_reg + 16'h0001 >= count_reg;
	wire halt = cStop || finDone || under || err_reg;
	wire [AW:0] rpNext = (rp_reg + 1'b1 == loadCnt_reg) ? '0 : rp_reg + 1'b1;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= DWTE_IDLE;
			dly_reg <= '0;
			divCnt_reg <= '0;
			done_reg <= '0;
			heldWait_reg <= 1'b0;
		end else begin
			heldWait_reg <= holdRaw ? 1'b1 : (strobe ? 1'b0 : heldWait_reg);
			if (divTick)
				divCnt_reg <= divWrap ? div_reg - 16'h0001 :
					divCnt_reg - 16'h0001;
			unique case (state_reg)
				DWTE_IDLE: if (go && !err_reg) begin
					state_reg <= onboard ? DWTE_DELAY : DWTE_RUN;
					dly_reg <= delay_reg;
					done_reg <= '0;
				end
				DWTE_DELAY: begin
					if (halt)
						state_reg <= DWTE_IDLE;
					else if (sourceClockTick) begin
						if (dly_reg <= 16'h0001) begin
							state_reg <= DWTE_RUN;
							divCnt_reg <= '0;
						end
						dly_reg <= dly_reg - 16'h0001;
					end
				end
				DWTE_RUN: begin
					if (take)
						done_reg <= done_reg + 16'h0001;
					if (halt)
						state_reg <= DWTE_IDLE;
				end
			endcase
		end
	end

	// fifo storage
	always_ff @(posedge clock) begin
		if (fifoWr)
			fifo[wp_reg[AW-1:0]] <= wrFrame;
	end
	// frames wider than the bus word are zero-extended, never sliced past 31
	wire [WPF-1:0] wrFrame = WPF'(regWdata);
	wire regenKeep = mode == DWTE_FIFO_REGEN;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_reg <= '0;
			rp_reg <= '0;
			fill_reg <= '0;
			loadCnt_reg <= '0;
			loaded_reg <= 1'b0;
		end else if (cStop && state_reg == DWTE_IDLE) begin
			wp_reg <= '0;
			rp_reg <= '0;
			fill_reg <= '0;
			loadCnt_reg <= '0;
			loaded_reg <= 1'b0;
		end else begin
			if (cLoadDone || (regenKeep && go))
				loaded_reg <= 1'b1;
			if (fifoWr) begin
				wp_reg <= (wp_reg + 1'b1 == (AW+1)'(DEPTH)) ? '0 : wp_reg + 1'b1;
				loadCnt_reg <= loadCnt_reg + 1'b1;
			end
			if (take && regenKeep)
				rp_reg <= rpNext;
			else if (take)
				rp_reg <= (rp_reg + 1'b1 == (AW+1)'(DEPTH)) ? '0 : rp_reg + 1'b1;
			if (fifoWr && !(take && !regenKeep))
				fill_reg <= fill_reg + 1'b1;
			else if (!fifoWr && take && !regenKeep)
				fill_reg <= fill_reg - 1'b1;
		end
	end

	// dac output latch; all channels change together
	wire nonbufUpd = mode == DWTE_NONBUF && updEvent && directNew_reg;
	wire swConv = mode == DWTE_SWTIMED && cConv;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dac_reg <= '0;
			upd_reg <= 1'b0;
			direct_reg <= '0;
			directNew_reg <= 1'b0;
		end else begin
			upd_reg <= take || nonbufUpd || swConv;
			if (wrData && !buffered)
				direct_reg <= wrFrame;
			directNew_reg <= (wrData && !buffered) ||
				(directNew_reg && !nonbufUpd);
			if (take)
				dac_reg <= fifo[rp_reg[AW-1:0]];
			else if (nonbufUpd)
				dac_reg <= direct_reg;
			else if (swConv)
				dac_reg <= wrFrame;
		end
	end

	// configuration and sticky error; set wins over clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg <= 3'h0;
			count_reg <= '0;
			div_reg <= `DWTE_DIV_RST;
			delay_reg <= `DWTE_DELAY_RST;
			goSrc_reg <= '0;
			holdSrc_reg <= '0;
			strbSrc_reg <= '0;
			route_reg <= '0;
			err_reg <= 1'b0;
		end else begin
			err_reg <= under || (err_reg && !cClr);
			if (regWrite) begin
				unique case (regAddr)
					`DWTE_A_MODE:    mode_reg <= regWdata[2:0];
					`DWTE_A_COUNT:   count_reg <= regWdata[15:0];
					`DWTE_A_DIV:     div_reg <= regWdata[15:0];
					`DWTE_A_DELAY:   delay_reg <= regWdata[15:0];
					`DWTE_A_GOSRC:   goSrc_reg <= regWdata[7:0];
					`DWTE_A_HOLDSRC: holdSrc_reg <= regWdata[7:0];
					`DWTE_A_STRBSRC: strbSrc_reg <= regWdata[7:0];
					`DWTE_A_ROUTE:   route_reg <= regWdata;
					default: ;
				endcase
			end
		end
	end

	// terminal routing: [7:0] pio start, [15:8] ibl start, [19:16] ibl pause,
	// [27:24] pio strobe with en [23], [30:28] ibl strobe with en [22]
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			goOut_reg <= 1'b0;
		else
			goOut_reg <= go && state_reg == DWTE_IDLE;
	end
	wire [3:0] goPio = route_reg[3:0];
	wire [3:0] strbPio = route_reg[27:24];
	wire [2:0] goIbl = route_reg[10:8];
	wire [2:0] holdIbl = route_reg[18:16];
	wire [2:0] strbIbl = route_reg[30:28];
	wire strbLow = !upd_reg;
	always_comb begin
		pioOut = '0;
		pioOe_n = '1; // inputs unless routed
		iblOut = '0;
		iblOe_n = '1;
		if (route_reg[4]) begin
			pioOut[goPio] = goOut_reg;
			pioOe_n[goPio] = 1'b0;
		end
		if (route_reg[11]) begin
			iblOut[goIbl] = goOut_reg;
			iblOe_n[goIbl] = 1'b0;
		end
		if (route_reg[19]) begin
			iblOut[holdIbl] = holdRaw;
			iblOe_n[holdIbl] = 1'b0;
		end
		if (route_reg[23]) begin
			pioOut[strbPio] = strbLow;
			pioOe_n[strbPio] = 1'b0;
		end
		if (route_reg[22]) begin
			iblOut[strbIbl] = strbLow;
			iblOe_n[strbIbl] = 1'b0;
		end
	end

	// register read, data one cycle after strobe
	wire [31:0] status = {16'h0, done_reg[7:0], 1'b0, fill_reg == '0,
		full, loaded_reg, err_reg, holdRaw, state_reg};
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		unique case (regAddr)
			`DWTE_A_MODE:    rdMux = {29'h0, mode_reg};
			`DWTE_A_COUNT:   rdMux = {16'h0, count_reg};
			`DWTE_A_DIV:     rdMux = {16'h0, div_reg};
			`DWTE_A_DELAY:   rdMux = {16'h0, delay_reg};
			`DWTE_A_GOSRC:   rdMux = {24'h0, goSrc_reg};
			`DWTE_A_HOLDSRC: rdMux = {24'h0, holdSrc_reg};
			`DWTE_A_STRBSRC: rdMux = {24'h0, strbSrc_reg};
			`DWTE_A_ROUTE:   rdMux = route_reg;
			`DWTE_A_STATUS:  rdMux = status;
			`DWTE_A_OUTVAL:  rdMux = 32'(dac_reg[WPF-1:0]);
			default:         rdMux = 32'h0;
		endcase
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rd_reg <= '0;
		else
			rd_reg <= regRead ? rdMux : 32'h0;
	end

	assign regRdata = rd_reg;
	assign dacData = dac_reg;
	assign dacUpdate = upd_reg;
	assign running = state_reg != DWTE_IDLE;
endmodule
`default_nettype wire

// File: verification/dwte_far_model.sv
// far-side model: timebase ticks, counter output, dac frame capture
`timescale 1ns/1ps
`default_nettype none
module dwte_far_model #(
	parameter int TICKDIV = 3,
	parameter int FW      = 32
) (
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire logic [FW-1:0] dacData,
	input  wire logic          dacUpdate,
	output logic               sourceClockTick,
	output logic               counterOut
);
	int          tickCnt;
	int          capCount;
	logic [FW-1:0] capture [0:31];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tickCnt         <= 0;
			sourceClockTick <= 1'b0;
			counterOut      <= 1'b0;
			capCount        <= 0;
		end else begin
			tickCnt         <= (tickCnt == TICKDIV - 1) ? 0 : tickCnt + 1;
			sourceClockTick <= (tickCnt == TICKDIV - 1);
			if (tickCnt == 0) begin
				counterOut <= !counterOut;
			end
			// whole frame taken per strobe: all converters move together
			if (dacUpdate) begin
				capture[capCount[4:0]] <= dacData;
				capCount               <= capCount + 1;
			end
		end
	end
endmodule
`default_nettype wire

// File: verification/dwte_timing_engine_asserts.sv
// port assertions for the waveform timing engine
`timescale 1ns/1ps
`default_nettype none
module dwte_timing_engine_asserts #(
	parameter int CHANNELS = 4,
	parameter int DACW     = 16
) (
	input wire logic                     clock,
	input wire logic                     rst,
	input wire logic [3:0]               regAddr,
	input wire logic [31:0]              regWdata,
	input wire logic                     regWrite,
	input wire logic                     regRead,
	input wire logic [31:0]              regRdata,
	input wire logic [15:0]              pioIn,
	input wire logic [CHANNELS*DACW-1:0] dacData,
	input wire logic                     dacUpdate,
	input wire logic                     running
);
	logic [2:0] modeCopy_reg;
	logic [7:0] holdCopy_reg;
	wire        ctrlWr = regWrite && regAddr == 4'h0;
	wire        hwMode = modeCopy_reg inside {3'h1, 3'h2, 3'h3, 3'h4};

	// shadows of mode and pause source, only to qualify antecedents
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			modeCopy_reg <= 3'h0;
			holdCopy_reg <= 8'h00;
		end else if (regWrite && regAddr == 4'h1) begin
			modeCopy_reg <= regWdata[2:0];
		end else if (regWrite && regAddr == 4'h6) begin
			holdCopy_reg <= regWdata[7:0];
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_oneUpd;
		dacUpdate ##1 !dacUpdate [*3];
	endsequence
	// five samples leave room for the two-flop synchroniser
	sequence s_holdOn;
		(holdCopy_reg == 8'h01 && pioIn[0]) [*5];
	endsequence

	a_rdata_quiet: assert property (!$past(regRead) |-> regRdata == 32'h0)
		else $error("read data not zero outside its slot");
	a_upd_pulse: assert property (dacUpdate |=> !dacUpdate)
		else $error("update strobe longer than one cycle");
	a_data_hold: assert property (!dacUpdate |-> $stable(dacData))
		else $error("dac data moved without an update");
	a_sw_one: assert property (
		ctrlWr && regWdata[4] && modeCopy_reg == 3'h0 |=> s_oneUpd)
		else $error("convert command did not give exactly one update");
	a_hold_quiet: assert property (s_holdOn |-> !dacUpdate)
		else $error("update while pause level held");
	a_idle_quiet: assert property ((hwMode && !running) [*3] |-> !dacUpdate)
		else $error("timed update while not running");
	a_go_run: assert property (
		ctrlWr && regWdata[0] && modeCopy_reg != 3'h0 |-> ##[1:3] running)
		else $error("start command did not start generation");
	a_stop_halt: assert property (ctrlWr && regWdata[1] |-> ##[1:3] !running)
		else $error("stop command did not end generation");
endmodule

bind dwte_timing_engine dwte_timing_engine_asserts #(
	.CHANNELS(CHANNELS),
	.DACW    (DACW)
) u_dwte_timing_engine_asserts (
	.clock    (clock),
	.rst      (rst),
	.regAddr  (regAddr),
	.regWdata (regWdata),
	.regWrite (regWrite),
	.regRead  (regRead),
	.regRdata (regRdata),
	.pioIn    (pioIn),
	.dacData  (dacData),
	.dacUpdate(dacUpdate),
	.running  (running)
);
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the waveform timing engine
`timescale 1ns/1ps
`default_nettype none
`include "dwte_consts.svh"
module tb_top;
	logic        clock, rst, regWrite, regRead, starIn, analogEvent;
	logic        inputStopRefEvent, inputBeginEvent, sourceClockTick;
	logic        counterOut, dacUpdate, running;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata, dacData, rv;
	logic [15:0] pioIn, pioOut, pioOe_n;
	logic [7:0]  iblIn, iblOut, iblOe_n;
	int          err_count, checks, base;

	dwte_timing_engine #(.CHANNELS(2), .DACW(16)) u_dwte_timing_engine (
		.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.pioIn(pioIn), .pioOut(pioOut), .pioOe_n(pioOe_n), .iblIn(iblIn),
		.iblOut(iblOut), .iblOe_n(iblOe_n), .starIn(starIn),
		.analogEvent(analogEvent), .inputStopRefEvent(inputStopRefEvent),
		.inputBeginEvent(inputBeginEvent), .counterOut(counterOut),
		.sourceClockTick(sourceClockTick), .dacData(dacData),
		.dacUpdate(dacUpdate), .running(running));
	dwte_far_model #(.TICKDIV(3), .FW(32)) u_dwte_far_model (
		.clock(clock), .rst(rst), .dacData(dacData), .dacUpdate(dacUpdate),
		.sourceClockTick(sourceClockTick), .counterOut(counterOut));

	always #20 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rv = regRdata;
	endtask
	task automatic waitRun(input logic lvl, input int n);
		for (int i = 0; i < n && running !== lvl; i++) @(posedge clock);
		#1 chk({31'h0, running}, {31'h0, lvl});
	endtask
	task automatic load(input int n, input logic [31:0] b);
		for (int i = 0; i < n; i++) wr(4'h9, b + i);
	endtask
	task automatic capChk(input int k, input logic [31:0] exp);
		chk(u_dwte_far_model.capture[(base + k) % 32], exp);
	endtask
	task automatic setLine(input int s, input logic v);
		case (s)
			2: pioIn[0] <= v;
			3: iblIn[0] <= v;
			4: inputStopRefEvent <= v;
			5: inputBeginEvent <= v;
			6: starIn <= v;
			default: analogEvent <= v;
		endcase
	endtask

	task automatic t_reset;
		chk({16'h0, pioOe_n}, 32'h0000_ffff);
		chk({24'h0, iblOe_n}, 32'h0000_00ff);
		rd(4'h3);
		chk(rv, {16'h0, `DWTE_DIV_RST});
		rd(4'h4);
		chk(rv, {16'h0, `DWTE_DELAY_RST});
		rd(4'hf);
		chk(rv, 32'h0);
	endtask
	task automatic t_sw;
		wr(4'h1, 32'h0);
		for (int i = 0; i < 3; i++) begin
			base = u_dwte_far_model.capCount;
			wr(4'h0, 32'h5a00_0010 + (i << 8));
			repeat (4) @(posedge clock);
			chk(u_dwte_far_model.capCount - base, 1);
			chk(dacData, 32'h5a00_0010 + (i << 8));
		end
	endtask
	task automatic t_fin;
		wr(4'h0, 32'h2);
		wr(4'h1, 32'h1);
		wr(4'h2, 32'h3);
		load(3, 32'h1111_0000);
		base = u_dwte_far_model.capCount;
		wr(4'h0, 32'h1);
		waitRun(1'b1, 10);
		waitRun(1'b0, 400);
		chk(u_dwte_far_model.capCount - base, 3);
		for (int i = 0; i < 3; i++) capChk(i, 32'h1111_0000 + i);
	endtask
	task automatic t_regen;
		wr(4'h0, 32'h2);
		wr(4'h1, 32'h3);
		load(2, 32'h2222_0000);
		wr(4'h0, 32'h20);
		wr(4'h9, 32'h2222_00ff);
		base = u_dwte_far_model.capCount;
		wr(4'h0, 32'h1);
		for (int i = 0; i < 400 && u_dwte_far_model.capCount - base < 5; i++)
			@(posedge clock);
		wr(4'h0, 32'h2);
		waitRun(1'b0, 4);
		for (int i = 0; i < 5; i++) capChk(i, 32'h2222_0000 + i % 2);
	endtask
	task automatic t_under;
		wr(4'h0, 32'h2);
		wr(4'h1, 32'h4);
		load(1, 32'h3333_0000);
		base = u_dwte_far_model.capCount;
		wr(4'h0, 32'h1);
		waitRun(1'b1, 10);
		waitRun(1'b0, 300);
		chk(u_dwte_far_model.capCount - base, 1);
		rd(4'ha);
		chk({31'h0, rv[3]}, 32'h1);
		wr(4'h0, 32'h8);
		rd(4'ha);
		chk({31'h0, rv[3]}, 32'h0);
	endtask
	task automatic t_hold;
		wr(4'h0, 32'h2);
		wr(4'h1, 32'h1);
		wr(4'h2, 32'h2);
		wr(4'h6, 32'h1);
		pioIn <= 16'h0001;
		load(2, 32'h4444_0000);
		base = u_dwte_far_model.capCount;
		wr(4'h0, 32'h1);
		repeat (60) @(posedge clock);
		chk(u_dwte_far_model.capCount - base, 0);
		chk({31'h0, running}, 32'h1);
		pioIn <= 16'h0000;
		waitRun(1'b0, 300);
		chk(u_dwte_far_model.capCount - base, 2);
		wr(4'h6, 32'h0);
	endtask
	task automatic t_go;
		wr(4'h1, 32'h1);
		wr(4'h2, 32'h1);
		for (int s = 1; s < 8; s++) begin
			for (int e = 0; e < 2; e++) begin
				if (e == 1 && (s == 1 || s == 7)) continue;
				wr(4'h0, 32'h2);
				load(1, 32'h5555_0000 + s);
				wr(4'h5, s);
				wr(4'h8, e << 31);
				setLine(s, e[0]);
				repeat (8) @(posedge clock);
				chk({31'h0, running}, 32'h0);
				if (s == 1) wr(4'h0, 32'h4);
				else setLine(s, ~e[0]);
				waitRun(1'b1, 12);
				waitRun(1'b0, 200);
				setLine(s, e[0]);
			end
		end
		wr(4'h5, 32'h0);
	endtask
	task automatic t_route;
		wr(4'h8, 32'h0000_0013);
		#1 chk({16'h0, pioOe_n}, 32'h0000_fff7);
		wr(4'h8, 32'h000b_0000);
		#1 chk({24'h0, iblOe_n}, 32'h0000_00f7);
		wr(4'h8, 32'h0580_0000);
		#1 chk({16'h0, pioOe_n}, 32'h0000_ffdf);
		chk({31'h0, pioOut[5]}, 32'h1);
	endtask

	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		{regWrite, regRead, starIn, analogEvent} = 4'h0;
		{inputStopRefEvent, inputBeginEvent} = 2'h0;
		{regAddr, regWdata, pioIn, iblIn} = 60'h0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_sw();
		t_fin();
		t_regen();
		t_under();
		t_hold();
		t_go();
		t_route();
		print_verdict();
	end
	// the full run needs well under 1000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
